// [logic/sbrw_cfg.svh]
// Purpose: constants for the staged boot and runtime watchdog
// Assumes: 40 MHz clock
// Notes:   times in seconds, counts derived in cycles
`ifndef SBRW_CFG_SVH
`define SBRW_CFG_SVH

// =====================================================================
// timing
`define SBRW_CLK_HZ        40000000
`define SBRW_SEC_S         1
`define SBRW_CYC_PER_SEC   (`SBRW_CLK_HZ * `SBRW_SEC_S)

// =====================================================================
// timeout table, seconds per code 0..9
`define SBRW_T0_S          11'h001
`define SBRW_T1_S          11'h002
`define SBRW_T2_S          11'h005
`define SBRW_T3_S          11'h00A
`define SBRW_T4_S          11'h01E
`define SBRW_T5_S          11'h03C
`define SBRW_T6_S          11'h078
`define SBRW_T7_S          11'h12C
`define SBRW_T8_S          11'h258
`define SBRW_T9_S          11'h708

// =====================================================================
// code offsets into the timeout table
`define SBRW_POST_OFS      4'h3
`define SBRW_DLY_OFS       4'h2

// =====================================================================
// mode and event codes
`define SBRW_MODE_DIS      2'h0
`define SBRW_MODE_ONCE     2'h1
`define SBRW_MODE_SINGLE   2'h2
`define SBRW_MODE_REPEAT   2'h3
`define SBRW_EV_DIS        2'h0
`define SBRW_EV_NOTIFY     2'h1
`define SBRW_EV_RESET      2'h2
`define SBRW_EV_PWRBTN     2'h3
`define SBRW_SEL_OFF       3'h0
`define SBRW_CNT_ONE       11'h001

`endif

// [logic/sbrw_pkg.sv]
// Purpose: types for the staged boot and runtime watchdog
// Assumes: constants come from sbrw_cfg.svh
// Notes:   none
package sbrw_pkg;

  // =====================================================================
  // runtime watchdog states
  typedef enum logic [2:0] {
    RT_OFF   = 3'b000,
    RT_DELAY = 3'b001,
    RT_S1    = 3'b010,
    RT_S2    = 3'b011,
    RT_S3    = 3'b100,
    RT_DONE  = 3'b101
  } sbrw_rt_t;

  // =====================================================================
  // configuration bundle
  typedef struct packed {
    logic [2:0] post_sel;
    logic       pause_en;
    logic [1:0] rt_mode;
    logic [2:0] delay_sel;
    logic [3:0] tmo1;
    logic [3:0] tmo2;
    logic [3:0] tmo3;
    logic [1:0] ev1;
    logic [1:0] ev2;
    logic [1:0] ev3;
    logic       notify_restart;
  } sbrw_cfg_t;

  // event pulses
  typedef struct packed {
    logic sys_reset;
    logic pwr_btn;
    logic notify_shutdown;
    logic notify_restart;
  } sbrw_evt_t;

  // all state of the top
  typedef struct packed {
    logic       post_run;
    logic       post_done;
    logic [10:0] post_cnt;
    sbrw_rt_t   rt_st;
    logic [10:0] rt_cnt;
    sbrw_evt_t  evt;
  } sbrw_state_t;

endpackage : sbrw_pkg

// [logic/sbrw_tick.sv]
// Purpose: one-second tick generator with restart
// Assumes: synchronous active-high reset
// Notes:   tick is a one-cycle pulse every CYC cycles after clr
`timescale 1ns/100ps
module sbrw_tick #(
  parameter int unsigned CYC = 40000000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clr,
  output logic      tick
);

  typedef struct packed {
    logic [25:0] cnt;
  } sbrw_tick_t;

  sbrw_tick_t st_ff;
  sbrw_tick_t nxt_st;
  localparam logic [25:0] LAST = 26'(CYC - 1);

  // =====================================================================
  // prescaler
  assign tick = (st_ff.cnt == LAST);

  always_comb begin
    nxt_st = st_ff;
    if (clr || tick) begin
      nxt_st.cnt = 26'h0000000;
    end else begin
      nxt_st.cnt = st_ff.cnt + 26'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : sbrw_tick

// [logic/sbrw_top.sv]
// Purpose: staged boot-time and runtime supervisory watchdog
// Assumes: all inputs synchronous to clk, config held steady
// Notes:   event outputs are one-cycle pulses
`timescale 1ns/100ps
`include "sbrw_cfg.svh"
module sbrw_top #(
  parameter int unsigned CYC_PER_SEC = `SBRW_CYC_PER_SEC
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire sbrw_pkg::sbrw_cfg_t cfg,
  input  wire logic               post_active,
  input  wire logic               user_wait,
  input  wire logic               os_boot,
  input  wire logic               wd_trigger,
  input  wire logic               cfg_load,
  output sbrw_pkg::sbrw_evt_t     evt_o,
  output sbrw_pkg::sbrw_rt_t      rt_state_o,
  output logic                    post_run_o
);

  // =====================================================================
  // timeout lookup
  function automatic logic [10:0] secs_of(input logic [3:0] code);
    logic [10:0] s;
    case (code)
      4'h0:    s = `SBRW_T0_S;
      4'h1:    s = `SBRW_T1_S;
      4'h2:    s = `SBRW_T2_S;
      4'h3:    s = `SBRW_T3_S;
      4'h4:    s = `SBRW_T4_S;
      4'h5:    s = `SBRW_T5_S;
      4'h6:    s = `SBRW_T6_S;
      4'h7:    s = `SBRW_T7_S;
      4'h8:    s = `SBRW_T8_S;
      default: s = `SBRW_T9_S;
    endcase
    return s;
  endfunction : secs_of

  // event code to pulses
  function automatic sbrw_pkg::sbrw_evt_t evt_of(input logic [1:0] code, input logic restart);
    sbrw_pkg::sbrw_evt_t e;
    e = '0;
    case (code)
      `SBRW_EV_NOTIFY: begin
        e.notify_shutdown = !restart;
        e.notify_restart  = restart;
      end
      `SBRW_EV_RESET:  e.sys_reset = 1'b1;
      `SBRW_EV_PWRBTN: e.pwr_btn   = 1'b1;
      default:         e = '0;
    endcase
    return e;
  endfunction : evt_of

  // =====================================================================
  // state
  sbrw_pkg::sbrw_state_t st_ff;
  sbrw_pkg::sbrw_state_t nxt_st;
  logic                  post_ld;
  logic                  rt_ld;
  logic                  post_tick;
  logic                  rt_tick;
  logic                  post_hold;
  logic                  post_exp;
  logic                  rt_exp;
  logic                  in_stage;
  logic [1:0]            ev1_code;
  logic [1:0]            stage_ev;
  logic [10:0]           t1_s;
  logic [10:0]           t2_s;
  logic [10:0]           t3_s;

  assign evt_o      = st_ff.evt;
  assign rt_state_o = st_ff.rt_st;
  assign post_run_o = st_ff.post_run;

  sbrw_tick #(.CYC(CYC_PER_SEC)) u_post_tick (
    .clk  (clk),
    .rst  (rst),
    .clr  (post_ld),
    .tick (post_tick)
  );

  sbrw_tick #(.CYC(CYC_PER_SEC)) u_rt_tick (
    .clk  (clk),
    .rst  (rst),
    .clr  (rt_ld),
    .tick (rt_tick)
  );

  // =====================================================================
  // decode helpers
  assign t1_s      = secs_of(cfg.tmo1);
  assign t2_s      = secs_of(cfg.tmo2);
  assign t3_s      = secs_of(cfg.tmo3);
  assign ev1_code  = (cfg.ev1 == 2'h3) ? `SBRW_EV_PWRBTN : cfg.ev1 + 2'h1;
  assign post_hold = cfg.pause_en && user_wait;
  assign post_exp  = st_ff.post_run && !post_hold && post_tick && (st_ff.post_cnt == `SBRW_CNT_ONE) &&
                     post_active && (cfg.post_sel != `SBRW_SEL_OFF);
  assign in_stage  = (st_ff.rt_st == sbrw_pkg::RT_S1) || (st_ff.rt_st == sbrw_pkg::RT_S2) ||
                     (st_ff.rt_st == sbrw_pkg::RT_S3);
  assign rt_exp    = in_stage && !wd_trigger && rt_tick && (st_ff.rt_cnt == `SBRW_CNT_ONE);

  always_comb begin
    case (st_ff.rt_st)
      sbrw_pkg::RT_S1: stage_ev = ev1_code;
      sbrw_pkg::RT_S2: stage_ev = cfg.ev2;
      sbrw_pkg::RT_S3: stage_ev = cfg.ev3;
      default:         stage_ev = `SBRW_EV_DIS;
    endcase
  end

  // =====================================================================
  // next state
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.evt = '0;
    post_ld    = 1'b0;
    rt_ld      = 1'b0;

    // boot-time watchdog
    if (!post_active || cfg.post_sel == `SBRW_SEL_OFF) begin
      nxt_st.post_run  = 1'b0;
      nxt_st.post_done = 1'b0;
    end else if (!st_ff.post_run && !st_ff.post_done) begin
      nxt_st.post_run = 1'b1;
      nxt_st.post_cnt = secs_of(4'(cfg.post_sel) + `SBRW_POST_OFS);
      post_ld         = 1'b1;
    end else if (st_ff.post_run && post_hold) begin
      post_ld = 1'b1;
    end else if (post_exp) begin
      nxt_st.post_run      = 1'b0;
      nxt_st.post_done     = 1'b1;
      nxt_st.evt.sys_reset = 1'b1;
    end else if (st_ff.post_run && post_tick) begin
      nxt_st.post_cnt = st_ff.post_cnt - 11'h001;
    end

    // runtime watchdog
    if (cfg_load) begin
      nxt_st.rt_st = sbrw_pkg::RT_OFF;
    end else begin
      case (st_ff.rt_st)
        sbrw_pkg::RT_OFF: begin
          if (os_boot && cfg.rt_mode != `SBRW_MODE_DIS) begin
            rt_ld = 1'b1;
            if (cfg.delay_sel == `SBRW_SEL_OFF) begin
              nxt_st.rt_st  = sbrw_pkg::RT_S1;
              nxt_st.rt_cnt = t1_s;
            end else begin
              nxt_st.rt_st  = sbrw_pkg::RT_DELAY;
              nxt_st.rt_cnt = secs_of(4'(cfg.delay_sel) + `SBRW_DLY_OFS);
            end
          end
        end
        sbrw_pkg::RT_DELAY: begin
          if (rt_tick && st_ff.rt_cnt == `SBRW_CNT_ONE) begin
            nxt_st.rt_st  = sbrw_pkg::RT_S1;
            nxt_st.rt_cnt = t1_s;
            rt_ld         = 1'b1;
          end else if (rt_tick) begin
            nxt_st.rt_cnt = st_ff.rt_cnt - 11'h001;
          end
        end
        sbrw_pkg::RT_S1, sbrw_pkg::RT_S2, sbrw_pkg::RT_S3: begin
          if (wd_trigger) begin
            rt_ld = 1'b1;
            if (cfg.rt_mode == `SBRW_MODE_ONCE) begin
              nxt_st.rt_st = sbrw_pkg::RT_DONE;
            end else begin
              nxt_st.rt_st  = sbrw_pkg::RT_S1;
              nxt_st.rt_cnt = t1_s;
            end
          end else if (rt_exp) begin
            // keep a boot reset raised in the same cycle
            nxt_st.evt = sbrw_pkg::sbrw_evt_t'(nxt_st.evt | evt_of(stage_ev, cfg.notify_restart));
            rt_ld      = 1'b1;
            if (st_ff.rt_st == sbrw_pkg::RT_S1) begin
              nxt_st.rt_st  = sbrw_pkg::RT_S2;
              nxt_st.rt_cnt = t2_s;
            end else if (st_ff.rt_st == sbrw_pkg::RT_S2) begin
              nxt_st.rt_st  = sbrw_pkg::RT_S3;
              nxt_st.rt_cnt = t3_s;
            end else if (cfg.rt_mode == `SBRW_MODE_REPEAT) begin
              nxt_st.rt_cnt = t3_s;
            end else begin
              nxt_st.rt_st = sbrw_pkg::RT_DONE;
            end
          end else if (rt_tick) begin
            nxt_st.rt_cnt = st_ff.rt_cnt - 11'h001;
          end
        end
        sbrw_pkg::RT_DONE: nxt_st.rt_st = sbrw_pkg::RT_DONE;
        default:           nxt_st.rt_st = sbrw_pkg::RT_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_post_off;
    cfg.post_sel == `SBRW_SEL_OFF |=> !st_ff.post_run;
  endproperty
  a_post_off: assert property (p_post_off) else $error("boot watchdog ran while off");

  property p_post_end;
    !post_active && !(rt_exp && stage_ev == `SBRW_EV_RESET) |=> !st_ff.post_run && !st_ff.evt.sys_reset;
  endproperty
  a_post_end: assert property (p_post_end) else $error("boot watchdog ran after self-test");

  property p_post_reset;
    post_exp |=> evt_o.sys_reset && !post_run_o;
  endproperty
  a_post_reset: assert property (p_post_reset) else $error("boot expiry gave no reset");

  property p_post_pause;
    st_ff.post_run && post_hold && post_active && cfg.post_sel != `SBRW_SEL_OFF
      |=> $stable(st_ff.post_cnt) && st_ff.post_run;
  endproperty
  a_post_pause: assert property (p_post_pause) else $error("boot count moved during pause");

  property p_arm;
    st_ff.rt_st == sbrw_pkg::RT_OFF && !cfg_load && os_boot && cfg.rt_mode != `SBRW_MODE_DIS
      |=> rt_state_o != sbrw_pkg::RT_OFF;
  endproperty
  a_arm: assert property (p_arm) else $error("runtime watchdog not armed");

  property p_once;
    in_stage && wd_trigger && !cfg_load && cfg.rt_mode == `SBRW_MODE_ONCE
      |=> rt_state_o == sbrw_pkg::RT_DONE ##1 evt_o == {$past(post_exp), 3'h0};
  endproperty
  a_once: assert property (p_once) else $error("one-time mode stayed armed");

  property p_single;
    rt_exp && !cfg_load && st_ff.rt_st == sbrw_pkg::RT_S3 && cfg.rt_mode == `SBRW_MODE_SINGLE
      |=> rt_state_o == sbrw_pkg::RT_DONE;
  endproperty
  a_single: assert property (p_single) else $error("single mode did not stop");

  property p_repeat;
    rt_exp && !cfg_load && st_ff.rt_st == sbrw_pkg::RT_S3 && cfg.rt_mode == `SBRW_MODE_REPEAT
      |=> rt_state_o == sbrw_pkg::RT_S3 && st_ff.rt_cnt == $past(t3_s);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat mode left last stage");

  property p_delay;
    st_ff.rt_st == sbrw_pkg::RT_OFF && !cfg_load && os_boot && cfg.rt_mode != `SBRW_MODE_DIS &&
      cfg.delay_sel != `SBRW_SEL_OFF |=> rt_state_o == sbrw_pkg::RT_DELAY;
  endproperty
  a_delay: assert property (p_delay) else $error("start delay skipped");

  property p_stage1_evt;
    rt_exp && !cfg_load && st_ff.rt_st == sbrw_pkg::RT_S1 && cfg.ev1 == 2'h1
      |=> evt_o.sys_reset ##1 evt_o.sys_reset == $past(post_exp);
  endproperty
  a_stage1_evt: assert property (p_stage1_evt) else $error("stage one reset missing");

  property p_stage_dis;
    rt_exp && !cfg_load && st_ff.rt_st == sbrw_pkg::RT_S2 && cfg.ev2 == `SBRW_EV_DIS
      |=> evt_o == {$past(post_exp), 3'h0};
  endproperty
  a_stage_dis: assert property (p_stage_dis) else $error("disabled stage raised event");

  property p_notify;
    rt_exp && !cfg_load && stage_ev == `SBRW_EV_NOTIFY
      |=> evt_o.notify_restart == $past(cfg.notify_restart) && evt_o.notify_shutdown != evt_o.notify_restart;
  endproperty
  a_notify: assert property (p_notify) else $error("notification kind wrong");

  property p_trigger;
    in_stage && wd_trigger && !cfg_load && cfg.rt_mode != `SBRW_MODE_ONCE
      |=> rt_state_o == sbrw_pkg::RT_S1 && st_ff.rt_cnt == $past(t1_s) && evt_o == {$past(post_exp), 3'h0};
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger did not restart stage one");

  property p_reset;
    disable iff (1'b0) rst |=> rt_state_o == sbrw_pkg::RT_OFF && !post_run_o && evt_o == '0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset left watchdog state");

endmodule : sbrw_top

// [verif/sbrw_top_tb.sv]
// Purpose: self-checking bench for sbrw_top
// Assumes: one second shortened to C cycles
// Notes:   event times checked within a window of a few cycles
`timescale 1ns/100ps
module sbrw_top_tb;
  localparam int C = 4;
  logic                clk;
  logic                rst;
  sbrw_pkg::sbrw_cfg_t cfg;
  logic                post_active;
  logic                user_wait;
  logic                os_boot;
  logic                wd_trigger;
  logic                cfg_load;
  sbrw_pkg::sbrw_evt_t evt_o;
  sbrw_pkg::sbrw_rt_t  rt_state_o;
  logic                post_run_o;
  int                  fail_count = 0;
  int                  check_count = 0;
  int                  cyc = 0;
  int                  seed = 32'h4302bb86;
  int                  k;

  sbrw_top #(.CYC_PER_SEC(C)) sbrw_top_i (.clk(clk), .rst(rst), .cfg(cfg), .post_active(post_active),
    .user_wait(user_wait), .os_boot(os_boot), .wd_trigger(wd_trigger), .cfg_load(cfg_load),
    .evt_o(evt_o), .rt_state_o(rt_state_o), .post_run_o(post_run_o));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // =====================================================
  // reference model
  function automatic int tmo_s(input int c);
    int t[10] = '{1, 2, 5, 10, 30, 60, 120, 300, 600, 1800};
    return t[(c > 9) ? 9 : c];
  endfunction : tmo_s

  function automatic int dly_s(input int c);
    int t[8] = '{0, 10, 30, 60, 120, 300, 600, 1800};
    return t[c];
  endfunction : dly_s

  function automatic int post_s(input int c);
    int t[8] = '{0, 30, 60, 120, 300, 600, 1800, 1800};
    return t[c];
  endfunction : post_s

  // stage one has no disabled code
  function automatic logic [3:0] ev_of(input int s, input int c, input logic rs);
    int e;
    e = (s == 1) ? c + 1 : c;
    case ((e > 3) ? 3 : e)
      1: return rs ? 4'h1 : 4'h2;
      2: return 4'h8;
      3: return 4'h4;
      default: return 4'h0;
    endcase
  endfunction : ev_of

  // =====================================================
  // checking and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // =====================================================
  // drivers
  task automatic pulse(input int w);
    @(posedge clk);
    os_boot    <= (w == 0);
    wd_trigger <= (w == 1);
    cfg_load   <= (w == 2);
    @(posedge clk);
    os_boot    <= 1'b0;
    wd_trigger <= 1'b0;
    cfg_load   <= 1'b0;
  endtask : pulse

  // waits for any output change, checks its time and event
  task automatic waitc(input int lo, input int hi, input logic [3:0] ev);
    logic [2:0] st;
    logic       pr;
    logic [3:0] seen;
    int         n;
    st = rt_state_o;
    pr = post_run_o;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (evt_o === 4'h0 && rt_state_o === st && post_run_o === pr && n <= hi);
    seen = evt_o;
    @(posedge clk);
    #1;
    seen = seen | evt_o;
    chk(16'(n >= lo && n <= hi), 16'h1, "event time");
    chk(16'(seen), 16'(ev), "event kind");
  endtask : waitc

  task automatic quiet(input int n);
    logic [3:0] acc;
    acc = 4'h0;
    repeat (n) begin
      @(posedge clk);
      #1;
      acc = acc | evt_o;
    end
    chk(16'(acc), 16'h0, "stray event");
  endtask : quiet

  task automatic boot_go(input int sel, input logic pe);
    @(posedge clk);
    cfg.post_sel <= 3'(sel);
    cfg.pause_en <= pe;
    post_active  <= 1'b1;
    @(posedge clk);
    #1;
  endtask : boot_go

  task automatic boot_off();
    @(posedge clk);
    post_active <= 1'b0;
    user_wait   <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : boot_off

  task automatic run_stages();
    int t;
    pulse(0);
    #1;
    if (cfg.delay_sel != 3'h0) begin
      chk(16'(rt_state_o), 16'h1, "delay state");
      t = dly_s(cfg.delay_sel) * C;
      waitc(t - 2, t + 2, 4'h0);
    end
    for (int s = 1; s <= 3; s++) begin
      t = tmo_s((s == 1) ? cfg.tmo1 : (s == 2) ? cfg.tmo2 : cfg.tmo3) * C;
      chk(16'(rt_state_o), 16'(s + 1), "stage state");
      waitc(t - 2, t + 2, ev_of(s, (s == 1) ? cfg.ev1 : (s == 2) ? cfg.ev2 : cfg.ev3, cfg.notify_restart));
    end
  endtask : run_stages

  // =====================================================
  // main sequence
  initial begin
    rst         = 1'b1;
    cfg         = '0;
    post_active = 1'b0;
    user_wait   = 1'b0;
    os_boot     = 1'b0;
    wd_trigger  = 1'b0;
    cfg_load    = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(16'({evt_o, rt_state_o, post_run_o}), 16'h0, "reset");
    for (k = 0; k < 8; k++) begin
      boot_go(k, 1'b0);
      chk(16'(post_run_o), 16'(k != 0), "boot run");
      if (k == 0) begin
        quiet(200);
      end else begin
        waitc(post_s(k) * C - 2, post_s(k) * C + 3, 4'h8);
      end
      quiet(20);
      chk(16'(post_run_o), 16'h0, "boot stop");
      boot_off();
    end
    for (k = 0; k < 2; k++) begin
      boot_go(1, k[0]);
      repeat (40) @(posedge clk);
      user_wait <= 1'b1;
      repeat (60) @(posedge clk);
      user_wait <= 1'b0;
      #1;
      waitc(k ? 78 : 18, k ? 87 : 23, 4'h8);
      boot_off();
    end
    boot_go(1, 1'b0);
    repeat (50) @(posedge clk);
    post_active <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(post_run_o), 16'h0, "boot halt");
    quiet(150);
    for (k = 0; k < 10; k++) begin
      @(posedge clk);
      cfg.rt_mode        <= 2'h2;
      cfg.delay_sel      <= 3'(k);
      cfg.tmo1           <= 4'(k);
      cfg.tmo2           <= 4'($random(seed) & 3);
      cfg.tmo3           <= 4'($random(seed) & 3);
      cfg.ev1            <= 2'(k);
      cfg.ev2            <= 2'(k + 1);
      cfg.ev3            <= 2'(k + 2);
      cfg.notify_restart <= k[0];
      run_stages();
      chk(16'(rt_state_o), 16'h5, "done");
      quiet(30);
      pulse(2);
    end
    @(posedge clk);
    cfg.rt_mode <= 2'h3;
    cfg.ev3     <= 2'(1 + ($random(seed) & 1));
    run_stages();
    repeat (2) begin
      chk(16'(rt_state_o), 16'h4, "repeat state");
      waitc(tmo_s(cfg.tmo3) * C - 2, tmo_s(cfg.tmo3) * C + 2, ev_of(3, cfg.ev3, cfg.notify_restart));
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(16'({evt_o, rt_state_o, post_run_o}), 16'h0, "mid reset");
    quiet(100);
    @(posedge clk);
    cfg.rt_mode   <= 2'h1;
    cfg.tmo1      <= 4'h1;
    cfg.delay_sel <= 3'h0;
    pulse(0);
    repeat (4) @(posedge clk);
    pulse(1);
    #1;
    chk(16'(rt_state_o), 16'h5, "one-time off");
    pulse(1);
    quiet(100);
    chk(16'(rt_state_o), 16'h5, "one-time stays");
    pulse(2);
    @(posedge clk);
    cfg.rt_mode <= 2'h2;
    cfg.tmo2    <= 4'h1;
    pulse(0);
    repeat (10) begin
      repeat (3) @(posedge clk);
      pulse(1);
    end
    #1;
    chk(16'(rt_state_o), 16'h2, "serviced");
    waitc(6, 10, ev_of(1, cfg.ev1, cfg.notify_restart));
    repeat (3) @(posedge clk);
    pulse(1);
    #1;
    chk(16'(rt_state_o), 16'h2, "restart stage one");
    pulse(2);
    @(posedge clk);
    cfg.rt_mode <= 2'h0;
    pulse(0);
    #1;
    chk(16'(rt_state_o), 16'h0, "mode off");
    quiet(50);
    tally_and_finish();
  end
endmodule : sbrw_top_tb
